/* File: common/ticc_consts.vh */
// Purpose: Register map, field positions and codes for the timer input
//          capture conditioning block.
// Assumes: Registers are reached over the plain address/strobe port.
// Notes:   Register offsets, field positions and codes live here as macros; the filter tables stay in the logic.
//
// Summary of operation
// - Channel two direction selects output, own, neighbour, trigger.
// - Channel one direction selects output, own, neighbour, trigger.
// - Trigger source works only with internal trigger.
// - Filter passes edge after N sampling events.
// - Code zero disables filter, samples at dead-time rate.
// - Codes one to three: internal clock, N 2/4/8.
// - Codes four to seven: dead-time /2 and /4.
// - Codes eight to twelve: dead-time /8 and /16.
// - Codes thirteen to fifteen: dead-time /32, N 5/6/8.
// - Prescaler captures every 1, 2, 4, 8 edges.
// - Prescaler counter clears while capture enable clear.
// - Field positions of filter, prescaler and direction bits.
// - Filter bits act in every direction; prescaler bits only for inputs.
`ifndef TICC_CONSTS_VH
`define TICC_CONSTS_VH

`define TICC_ADDR_W        8
`define TICC_DATA_W        32

`define TICC_OFF_MODE      8'h00
`define TICC_OFF_CTRL      8'h04
`define TICC_OFF_STATUS    8'h08
`define TICC_OFF_MASK      8'h0c
`define TICC_OFF_STATE     8'h10

`define TICC_MODE_RESET    16'h0000
`define TICC_DIR_LSB_ONE   0
`define TICC_PSC_LSB_ONE   2
`define TICC_FLT_LSB_ONE   4
`define TICC_DIR_LSB_TWO   8
`define TICC_PSC_LSB_TWO   10
`define TICC_FLT_LSB_TWO   12

`define TICC_CTRL_EN_LSB   0
`define TICC_CTRL_TSEL_LSB 4
`define TICC_CTRL_DTS_LSB  8
`define TICC_TSEL_EXT_MIN  3'h4

`define TICC_DIR_OUTPUT    2'h0
`define TICC_DIR_OWN       2'h1
`define TICC_DIR_CROSS     2'h2
`define TICC_DIR_TRIGGER   2'h3

`endif

/* File: rtl/ticc_capture_cond.v */
// Purpose: Input conditioning for two timer capture channels: source
//          selection, digital sampling filter and active-edge prescaler.
// Assumes: All inputs are synchronous to clk; the active edge is rising.
// Notes:   Capture pulses and a masked interrupt leave the block; the
//          capture registers themselves live elsewhere.
`timescale 1ns/100ps
`include "ticc_consts.vh"

module ticc_capture_cond (
	// Clock and reset
	input  wire                      clk,
	input  wire                      reset_n,
	// Register port
	input  wire [`TICC_ADDR_W-1:0]   regAddr,
	input  wire [`TICC_DATA_W-1:0]   regWrData,
	input  wire                      regWr,
	input  wire                      regRd,
	output wire [`TICC_DATA_W-1:0]   regRdData,
	// Channel pins and trigger
	input  wire                      pinOne,
	input  wire                      pinTwo,
	input  wire                      slaveTriggerInput,
	// Capture events
	output wire                      chOneCapture,
	output wire                      chTwoCapture,
	output wire                      irq
);

	reg  [1:0]               rstSync;
	wire                     rstN;
	reg  [15:0]              channelModeOneCaptureLayout;
	reg  [1:0]               captureEnable;
	reg  [2:0]               triggerSourceSelect;
	reg  [1:0]               deadTimeDivSel;
	reg  [1:0]               status;
	reg  [1:0]               mask;
	reg  [`TICC_DATA_W-1:0]  rdData;
	reg                      irqReg;
	reg  [2:0]               dtsCnt;
	reg                      dtsTick;
	wire [1:0]               pinIn;
	wire [1:0]               filtered;
	wire [1:0]               selected;
	wire [1:0]               capture;
	wire [5:0]               edgeCounts;
	wire [1:0]               next_status;
	wire                     trigUsable;
	wire [3:0]               filterCode [0:1];
	wire [1:0]               prescalerCode [0:1];
	wire [1:0]               directionCode [0:1];

	assign pinIn = {pinTwo, pinOne};

	// Reset is released through two flops so the release is clean.
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rstSync <= 2'h0;
		end else begin
			rstSync <= {rstSync[0], 1'b1};
		end
	end
	assign rstN = rstSync[1];

	assign filterCode[0]    = channelModeOneCaptureLayout[`TICC_FLT_LSB_ONE +: 4];
	assign filterCode[1]    = channelModeOneCaptureLayout[`TICC_FLT_LSB_TWO +: 4];
	assign prescalerCode[0] = channelModeOneCaptureLayout[`TICC_PSC_LSB_ONE +: 2];
	assign prescalerCode[1] = channelModeOneCaptureLayout[`TICC_PSC_LSB_TWO +: 2];
	assign directionCode[0] = channelModeOneCaptureLayout[`TICC_DIR_LSB_ONE +: 2];
	assign directionCode[1] = channelModeOneCaptureLayout[`TICC_DIR_LSB_TWO +: 2];

	// The slave trigger is only meaningful with an internal trigger input.
	assign trigUsable = (triggerSourceSelect < `TICC_TSEL_EXT_MIN);

	// Number of matching samples needed for each filter code.
	function [3:0] filtN;
		input [3:0] code;
		begin
			case (code)
				4'h0: filtN = 4'h1;
				4'h1: filtN = 4'h2;
				4'h2: filtN = 4'h4;
				4'h3: filtN = 4'h8;
				4'h4: filtN = 4'h6;
				4'h5: filtN = 4'h8;
				4'h6: filtN = 4'h6;
				4'h7: filtN = 4'h8;
				4'h8: filtN = 4'h6;
				4'h9: filtN = 4'h8;
				4'ha: filtN = 4'h5;
				4'hb: filtN = 4'h6;
				4'hc: filtN = 4'h8;
				4'hd: filtN = 4'h5;
				4'he: filtN = 4'h6;
				default: filtN = 4'h8;
			endcase
		end
	endfunction

	// Divider applied to the dead-time tick; zero means internal clock rate.
	function [5:0] filtDiv;
		input [3:0] code;
		begin
			case (code)
				4'h0: filtDiv = 6'h01;
				4'h1, 4'h2, 4'h3: filtDiv = 6'h00;
				4'h4, 4'h5: filtDiv = 6'h02;
				4'h6, 4'h7: filtDiv = 6'h04;
				4'h8, 4'h9: filtDiv = 6'h08;
				4'ha, 4'hb, 4'hc: filtDiv = 6'h10;
				default: filtDiv = 6'h20;
			endcase
		end
	endfunction

	// Dead-time sample tick: clk divided by 1, 2 or 4 as programmed.
	always @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			dtsCnt  <= 3'h0;
			dtsTick <= 1'b0;
		end else begin
			case (deadTimeDivSel)
				2'h1: begin
					dtsTick <= (dtsCnt[0] == 1'b1);
					dtsCnt  <= {2'h0, ~dtsCnt[0]};
				end
				2'h2, 2'h3: begin
					dtsTick <= (dtsCnt[1:0] == 2'h3);
					dtsCnt  <= {1'b0, dtsCnt[1:0] + 2'h1};
				end
				default: begin
					dtsTick <= 1'b1;
					dtsCnt  <= 3'h0;
				end
			endcase
		end
	end

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : chan
			reg  [5:0] divCnt;
			reg  [3:0] matchCnt;
			reg        level;
			reg        prevSel;
			reg  [2:0] edgeCnt;
			reg        capPulse;
			reg        selIn;
			wire [5:0] divide;
			wire [3:0] needN;
			wire       sampleEvent;
			wire       active;
			wire [2:0] edgeLimit;

			assign divide = filtDiv(filterCode[ch]);
			assign needN  = filtN(filterCode[ch]);
			// Internal-clock codes sample every clk; others on divided ticks.
			assign sampleEvent = (divide == 6'h00) ? 1'b1 :
				(dtsTick && (divCnt == divide - 6'h01));

			always @(posedge clk or negedge rstN) begin
				if (!rstN) begin
					divCnt <= 6'h00;
				end else if (divide == 6'h00) begin
					divCnt <= 6'h00;
				end else if (dtsTick) begin
					divCnt <= (divCnt >= divide - 6'h01) ? 6'h00 : divCnt + 6'h01;
				end
			end

			// A sample differing from the held level is a candidate; any
			// agreeing sample throws the count away.
			always @(posedge clk or negedge rstN) begin
				if (!rstN) begin
					matchCnt <= 4'h0;
					level    <= 1'b0;
				end else if (sampleEvent) begin
					if (pinIn[ch] == level) begin
						matchCnt <= 4'h0;
					end else if (matchCnt + 4'h1 >= needN) begin
						level    <= pinIn[ch];
						matchCnt <= 4'h0;
					end else begin
						matchCnt <= matchCnt + 4'h1;
					end
				end
			end
			assign filtered[ch] = level;

			// Source mux for this channel.
			always @* begin
				case (directionCode[ch])
					`TICC_DIR_OWN:     selIn = filtered[ch];
					`TICC_DIR_CROSS:   selIn = filtered[1-ch];
					`TICC_DIR_TRIGGER: selIn = trigUsable & slaveTriggerInput;
					default:           selIn = 1'b0;
				endcase
			end
			assign selected[ch] = selIn;

			// Prescaler bits only count for an enabled input; the filter runs in every direction.
			assign active = captureEnable[ch] &&
				(directionCode[ch] != `TICC_DIR_OUTPUT);
			assign edgeLimit = (prescalerCode[ch] == 2'h0) ? 3'h0 :
				(prescalerCode[ch] == 2'h1) ? 3'h1 :
				(prescalerCode[ch] == 2'h2) ? 3'h3 : 3'h7;

			// Direction is assumed stable while enabled, so the edge
			// detector never sees a mux switch as an edge.
			always @(posedge clk or negedge rstN) begin
				if (!rstN) begin
					prevSel  <= 1'b0;
					edgeCnt  <= 3'h0;
					capPulse <= 1'b0;
				end else begin
					prevSel  <= selIn;
					capPulse <= 1'b0;
					if (!active) begin
						edgeCnt <= 3'h0;
					end else if (selIn && !prevSel) begin
						if (edgeCnt >= edgeLimit) begin
							edgeCnt  <= 3'h0;
							capPulse <= 1'b1;
						end else begin
							edgeCnt <= edgeCnt + 3'h1;
						end
					end
				end
			end
			assign capture[ch]          = capPulse;
			assign edgeCounts[3*ch +: 3] = edgeCnt;
		end
	endgenerate

	// Set wins over a write-one clear in the same cycle.
	assign next_status = capture |
		(status & ~((regWr && regAddr == `TICC_OFF_STATUS) ? regWrData[1:0] : 2'h0));

	always @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			channelModeOneCaptureLayout <= `TICC_MODE_RESET;
			captureEnable       <= 2'h0;
			triggerSourceSelect <= 3'h0;
			deadTimeDivSel      <= 2'h0;
			mask                <= 2'h0;
			status              <= 2'h0;
			irqReg              <= 1'b0;
		end else begin
			status <= next_status;
			irqReg <= |(next_status & mask);
			if (regWr) begin
				case (regAddr)
					`TICC_OFF_MODE: begin
						channelModeOneCaptureLayout <= regWrData[15:0];
					end
					`TICC_OFF_CTRL: begin
						captureEnable       <= regWrData[`TICC_CTRL_EN_LSB +: 2];
						triggerSourceSelect <= regWrData[`TICC_CTRL_TSEL_LSB +: 3];
						deadTimeDivSel      <= regWrData[`TICC_CTRL_DTS_LSB +: 2];
					end
					`TICC_OFF_MASK: begin
						mask <= regWrData[1:0];
					end
					default: begin
						mask <= mask;
					end
				endcase
			end
			if (regWr && regAddr == `TICC_OFF_MASK) begin
				irqReg <= |(next_status & regWrData[1:0]);
			end
		end
	end

	// Read data is valid the cycle after the strobe only; zero otherwise.
	always @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			rdData <= 32'h0000_0000;
		end else if (regRd) begin
			case (regAddr)
				`TICC_OFF_MODE:   rdData <= {16'h0000, channelModeOneCaptureLayout};
				`TICC_OFF_CTRL:   rdData <= {22'h000000, deadTimeDivSel, 1'b0,
					triggerSourceSelect, 2'h0, captureEnable};
				`TICC_OFF_STATUS: rdData <= {30'h00000000, status};
				`TICC_OFF_MASK:   rdData <= {30'h00000000, mask};
				`TICC_OFF_STATE:  rdData <= {22'h000000, edgeCounts, selected, filtered};
				default:          rdData <= 32'h0000_0000;
			endcase
		end else begin
			rdData <= 32'h0000_0000;
		end
	end

	assign regRdData    = rdData;
	assign chOneCapture = capture[0];
	assign chTwoCapture = capture[1];
	assign irq          = irqReg;

endmodule

/* File: verif/ticc_capture_cond_sva.sv */
// Purpose: Port checks for ticc_capture_cond.
// Assumes: Mode and control writes are mirrored here from the bus.
// Notes:   A capture follows the last matching sample by two cycles.
`timescale 1ns/100ps
`include "ticc_consts.vh"
module ticc_capture_cond_sva (
	// Watched ports
	input wire        clk,
	input wire        reset_n,
	input wire [7:0]  regAddr,
	input wire [31:0] regWrData,
	input wire        regWr,
	input wire        regRd,
	input wire [31:0] regRdData,
	input wire        pinOne,
	input wire        pinTwo,
	input wire        chOneCapture,
	input wire        chTwoCapture,
	input wire        irq
);
	reg [15:0] md;
	reg [9:0]  ct;
	always @(posedge clk or negedge reset_n)
		if (!reset_n) {md, ct} <= 26'h0;
		else if (regWr && regAddr == `TICC_OFF_MODE) md <= regWrData[15:0];
		else if (regWr && regAddr == `TICC_OFF_CTRL) ct <= regWrData[9:0];
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	property p_modeRead;
		$past(regRd) && $past(regAddr) == `TICC_OFF_MODE |-> regRdData == {16'h0, $past(md)};
	endproperty
	a_modeRead: assert property (p_modeRead) else $error("mode readback");
	property p_enabled;
		chOneCapture |-> $past(ct[0]) && $past(md[1:0]) != 2'h0;
	endproperty
	a_enabled: assert property (p_enabled) else $error("capture while off");
	property p_pulse;
		chOneCapture |=> !chOneCapture;
	endproperty
	a_pulse: assert property (p_pulse) else $error("capture too long");
	property p_oneSource;
		chOneCapture |-> (md[1:0] != 2'h1 || $past(pinOne, 2))
			&& (md[1:0] != 2'h2 || $past(pinTwo, 2));
	endproperty
	a_oneSource: assert property (p_oneSource) else $error("channel one source");
	property p_twoCross;
		chTwoCapture && md[9:8] == 2'h2 |-> $past(pinOne, 2) && $past(ct[1]);
	endproperty
	a_twoCross: assert property (p_twoCross) else $error("channel two source");
	property p_trigInt;
		chOneCapture && md[1:0] == 2'h3 |-> !ct[6];
	endproperty
	a_trigInt: assert property (p_trigInt) else $error("external trigger used");
	property p_longFilter;
		chOneCapture && md[7:0] == 8'h31 |-> $past(pinOne, 2) && $past(pinOne, 9);
	endproperty
	a_longFilter: assert property (p_longFilter) else $error("filter too short");
	property p_irqCause;
		$rose(irq) |-> $past(chOneCapture || chTwoCapture || regWr);
	endproperty
	a_irqCause: assert property (p_irqCause) else $error("irq without cause");
	cover property (chOneCapture && md[3:2] == 2'h3);
	cover property (chTwoCapture && md[9:8] == 2'h2);
	cover property ($rose(irq));
endmodule
bind ticc_capture_cond ticc_capture_cond_sva ticc_capture_cond_sva_inst (.clk, .reset_n,
	.regAddr, .regWrData, .regWr, .regRd, .regRdData, .pinOne, .pinTwo,
	.chOneCapture, .chTwoCapture, .irq);

/* File: verif/ticc_pin_model.sv */
// Purpose: Far side: drives the two channel pins and the slave trigger.
// Assumes: The lines are synchronous to clk and always driven.
// Notes:   Edges are whole cycles high then low.
`timescale 1ns/100ps
module ticc_pin_model (
	// Clock and lines
	input  wire  clk,
	output logic pinOne = 1'b0,
	output logic pinTwo = 1'b0,
	output logic slaveTriggerInput = 1'b0
);
	task automatic drive(input int w, input logic v);
		@(posedge clk);
		if (w == 0) pinOne <= v;
		else if (w == 1) pinTwo <= v;
		else slaveTriggerInput <= v;
	endtask
	task automatic edges(input int w, input int n, input int hi, input int lo);
		repeat (n) begin
			drive(w, 1'b1);
			repeat (hi - 1) @(posedge clk);
			drive(w, 1'b0);
			repeat (lo - 1) @(posedge clk);
		end
	endtask
endmodule

/* File: verif/ticc_capture_cond_tb_top.sv */
// Purpose: Self-checking bench for ticc_capture_cond.
// Assumes: Pins come from ticc_pin_model; registers via the strobe port.
// Notes:   Filter delay is judged within one sample period of phase.
`timescale 1ns/100ps
`include "ticc_consts.vh"
module ticc_capture_cond_tb_top;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [7:0]  regAddr = 8'h00;
	logic [31:0] regWrData = 32'h0;
	logic        regWr = 1'b0;
	logic        regRd = 1'b0;
	logic [31:0] rv;
	wire  [31:0] regRdData;
	wire         pinOne, pinTwo, slaveTriggerInput, chOneCapture, chTwoCapture, irq;
	int          err_count = 0, samples_checked = 0, nc = 0, lat;
	int          dv[16] = '{1, 1, 1, 1, 2, 2, 4, 4, 8, 8, 16, 16, 16, 32, 32, 32};
	int          nn[16] = '{1, 2, 4, 8, 6, 8, 6, 8, 6, 8, 5, 6, 8, 5, 6, 8};
	always #50 clk = ~clk;
	always @(posedge clk) if (chOneCapture === 1'b1 || chTwoCapture === 1'b1) nc++;
	ticc_capture_cond ticc_capture_cond_inst (.clk, .reset_n, .regAddr, .regWrData, .regWr,
		.regRd, .regRdData, .pinOne, .pinTwo, .slaveTriggerInput, .chOneCapture,
		.chTwoCapture, .irq);
	ticc_pin_model ticc_pin_model_inst (.clk, .pinOne, .pinTwo, .slaveTriggerInput);
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		{regAddr, regWrData, regWr} <= {a, d, 1'b1};
		@(posedge clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		{regAddr, regRd} <= {a, 1'b1};
		@(posedge clk);
		regRd <= 1'b0;
		#1 d = regRdData;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic test_done;
		$display("checks=%0d errors=%0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Mode is only rewritten with both channels disabled.
	task automatic setup(input logic [15:0] m, input logic [9:0] c);
		wr(`TICC_OFF_CTRL, 32'h0);
		wr(`TICC_OFF_MODE, {16'h0, m});
		wr(`TICC_OFF_CTRL, {22'h0, c});
		nc = 0;
	endtask
	// The whole sequence needs about 7200 cycles.
	initial begin
		#4_000_000;
		err_count++;
		test_done;
	end
	initial begin
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd(`TICC_OFF_MODE, rv);
		chk(rv, 32'h0);
		wr(`TICC_OFF_MODE, 32'hffff_a5c3);
		rd(`TICC_OFF_MODE, rv);
		chk(rv, 32'h0000_a5c3);
		rd(8'h40, rv);
		chk(rv, 32'h0);
		$display("registers done");
		for (int c = 0; c < 16; c++) begin
			setup({8'h00, 4'(c), 4'h1}, 10'h001);
			ticc_pin_model_inst.drive(0, 1'b1);
			lat = 0;
			while (chOneCapture !== 1'b1 && lat < 1000) begin
				@(posedge clk);
				#1 lat++;
			end
			chk(lat >= (nn[c] - 1) * dv[c] + 1 && lat <= nn[c] * dv[c] + 3, 1);
			ticc_pin_model_inst.drive(0, 1'b0);
			repeat (300) @(posedge clk);
		end
		// Dead-time tick at clk/4 with code 5 (tick/2, N=8): one sample per 8 clocks.
		setup(16'h0051, 10'h201);
		ticc_pin_model_inst.drive(0, 1'b1);
		lat = 0;
		while (chOneCapture !== 1'b1 && lat < 1000) begin
			@(posedge clk);
			#1 lat++;
		end
		chk(lat >= 57 && lat <= 67, 1);
		ticc_pin_model_inst.drive(0, 1'b0);
		repeat (300) @(posedge clk);
		setup(16'h0031, 10'h001);
		ticc_pin_model_inst.edges(0, 1, 7, 20);
		chk(nc, 0);
		ticc_pin_model_inst.edges(0, 1, 9, 20);
		chk(nc, 1);
		$display("filter done");
		for (int p = 0; p < 4; p++) begin
			setup({12'h000, 2'(p), 2'h1}, 10'h001);
			ticc_pin_model_inst.edges(0, 8, 2, 2);
			repeat (4) @(posedge clk);
			chk(nc, 8 >> p);
		end
		setup(16'h000d, 10'h001);
		ticc_pin_model_inst.edges(0, 4, 2, 2);
		wr(`TICC_OFF_CTRL, 32'h0);
		wr(`TICC_OFF_CTRL, 32'h1);
		ticc_pin_model_inst.edges(0, 4, 2, 2);
		repeat (4) @(posedge clk);
		chk(nc, 0);
		$display("prescaler done");
		for (int ch = 0; ch < 2; ch++)
			for (int d = 0; d < 4; d++) begin
				setup(16'(d << (8 * ch)), 10'(1 << ch));
				ticc_pin_model_inst.edges(1 - ch, 4, 3, 3);
				chk(nc, d == 2 ? 4 : 0);
				nc = 0;
				ticc_pin_model_inst.edges(2, 4, 3, 3);
				chk(nc, d == 3 ? 4 : 0);
			end
		setup(16'h0003, 10'h041);
		ticc_pin_model_inst.edges(2, 4, 3, 3);
		chk(nc, 0);
		$display("direction done");
		setup(16'h0001, 10'h001);
		wr(`TICC_OFF_STATUS, 32'h3);
		wr(`TICC_OFF_MASK, 32'h1);
		ticc_pin_model_inst.edges(0, 1, 3, 3);
		chk(irq, 1);
		rd(`TICC_OFF_STATUS, rv);
		chk(rv, 32'h1);
		wr(`TICC_OFF_MASK, 32'h2);
		@(posedge clk);
		#1 chk(irq, 0);
		wr(`TICC_OFF_MASK, 32'h1);
		wr(`TICC_OFF_STATUS, 32'h1);
		@(posedge clk);
		#1 chk(irq, 0);
		rd(`TICC_OFF_STATUS, rv);
		chk(rv, 32'h0);
		$display("interrupt done");
		test_done;
	end
endmodule
